// ===== timer_chan.sv
`timescale 1ns/1ps
package timer_pkg;
  localparam int COUNT_W = 16;
  localparam int TICK_DIV = 4;
  localparam int PSAVE_W = 8;
  localparam logic [COUNT_W-1:0] COUNT_RESET = 16'h0000;
  localparam real CLK_PERIOD_NS = 10.0;

  // mode word fields, msb first
  typedef struct packed {
    logic enable;
    logic dual_limit;
    logic continuous;
    logic prescale_src;
    logic int_en;
  } mode_type;

  typedef struct packed {
    logic [COUNT_W-1:0] a;
    logic [COUNT_W-1:0] b;
  } limit_type;

  typedef struct packed {
    logic pulse_width_demod_bit;
    logic power_save;
    logic [PSAVE_W-1:0] psave_div;
  } sysconf_type;

  typedef struct packed {
    logic [COUNT_W-1:0] first;
    logic [COUNT_W-1:0] second;
    logic [COUNT_W-1:0] third;
  } counts_type;
endpackage

module timer_chan #(
  parameter int WIDTH = 16,
  parameter bit HAS_B = 1'b1
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic adv,
  input wire timer_pkg::mode_type mode,
  input wire logic [WIDTH-1:0] limit_a,
  input wire logic [WIDTH-1:0] limit_b,
  output logic [WIDTH-1:0] count_reg,
  output logic out_reg,
  output logic phase_b_reg,
  output logic full_reg,
  output logic irq_reg
);
  import timer_pkg::*;

  logic stopped_reg;
  logic dual;
  logic [WIDTH-1:0] lim;
  logic term;

  if (WIDTH < 2) begin : g_width_check
    $error("timer width too small");
  end

  assign dual = HAS_B && mode.dual_limit;
  assign lim = (dual && phase_b_reg) ? limit_b : limit_a;
  // a limit of zero wraps at the full 2**WIDTH count
  assign term = (count_reg == lim - WIDTH'(1));

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      count_reg <= '0;
      phase_b_reg <= 1'b0;
      stopped_reg <= 1'b0;
    end else if (!mode.enable) begin
      stopped_reg <= 1'b0;
      phase_b_reg <= 1'b0;
    end else if (adv && !stopped_reg) begin
      if (term) begin
        count_reg <= '0;
        if (dual) begin
          phase_b_reg <= ~phase_b_reg;
        end
        if (!mode.continuous && (!dual || phase_b_reg)) begin
          stopped_reg <= 1'b1;
        end
      end else begin
        count_reg <= count_reg + WIDTH'(1);
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      out_reg <= 1'b0;
      full_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      full_reg <= 1'b0;
      irq_reg <= 1'b0;
      if (mode.enable && dual) begin
        out_reg <= (adv && !stopped_reg && term) ? phase_b_reg : ~phase_b_reg;
      end
      if (mode.enable && adv && !stopped_reg && term) begin
        if (!dual) begin
          out_reg <= ~out_reg;
        end
        full_reg <= !dual || phase_b_reg;
        // end of the A phase only interrupts when the mode asks for it
        irq_reg <= !dual || phase_b_reg || mode.int_en;
      end
    end
  end
endmodule

// ===== triple_timer_pwm_pwd.sv
`timescale 1ns/1ps
// Overview of operation
// - all timers advance on a tick at one quarter of the processor clock
// - in power save the tick slows in proportion to the divided clock
// - every timer is a sixteen bit up counter
// - first and second timers each hold two software limits, A and B
// - dual-limit output is high while counting to A, low while counting to B
// - third timer has a single limit and always counts the tick: it ignores its count source bit and demodulation
// - third timer full count can serve as count source for first or second
// - first and second timers each have their own mode word
// - a timer raises an interrupt at full count; mode may add more
// - demodulation bit in system config puts timers in pulse width measuring
// - in demodulation every rising and falling input edge raises an interrupt
// - current counts are readable at any time without disturbing counting
module triple_timer_pwm_pwd (
  input wire logic mclk,
  input wire logic rst_b,
  input wire timer_pkg::sysconf_type system_config_reg,
  input wire timer_pkg::mode_type first_timer_mode_reg,
  input wire timer_pkg::mode_type second_timer_mode_reg,
  input wire timer_pkg::mode_type third_timer_mode_reg,
  input wire timer_pkg::limit_type first_limits,
  input wire timer_pkg::limit_type second_limits,
  input wire logic [timer_pkg::COUNT_W-1:0] third_limit,
  input wire logic demod_in,
  output timer_pkg::counts_type counts,
  output logic first_timer_out,
  output logic second_timer_out,
  output logic third_timer_out,
  output logic [2:0] timer_irq,
  output logic demod_rise_irq,
  output logic demod_fall_irq
);
  import timer_pkg::*;

  localparam int DIV_W = PSAVE_W + 3;

  logic [DIV_W-1:0] div_cnt_reg;
  logic [DIV_W-1:0] div_lim;
  logic tick_reg;
  logic demod_meta_reg;
  logic demod_sync_reg;
  logic demod_last_reg;
  logic demod_rise_reg;
  logic demod_fall_reg;
  logic pwd;
  logic adv0;
  logic adv1;
  logic adv2;
  logic full0;
  logic full2;
  logic irq0;
  logic irq1;
  logic irq2;
  logic ph0;
  logic [DIV_W-1:0] since_tick_reg;
  sysconf_type cfg_prev_reg;
  logic [3:0] cfg_age_reg;
  logic cfg_same;

  function automatic logic [DIV_W-1:0] tick_period(input logic ps, input logic [PSAVE_W-1:0] d);
    logic [DIV_W-1:0] m;
    m = (d == '0) ? DIV_W'(1) : DIV_W'(d);
    tick_period = ps ? DIV_W'(m * DIV_W'(TICK_DIV)) : DIV_W'(TICK_DIV);
  endfunction

  function automatic logic pick_src(input mode_type m, input logic tk, input logic t2full);
    pick_src = m.prescale_src ? t2full : tk;
  endfunction

  assign div_lim = tick_period(system_config_reg.power_save, system_config_reg.psave_div);

  // single tick pulse shared by all three timers keeps them phase aligned
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      div_cnt_reg <= '0;
      tick_reg <= 1'b0;
    end else if (div_cnt_reg >= div_lim - DIV_W'(1)) begin
      div_cnt_reg <= '0;
      tick_reg <= 1'b1;
    end else begin
      div_cnt_reg <= div_cnt_reg + DIV_W'(1);
      tick_reg <= 1'b0;
    end
  end

  // assertion helpers: cycles since the last tick, and how long the config has held still
  assign cfg_same = (system_config_reg == cfg_prev_reg);

  // saturates so a stalled tick cannot wrap back into a legal-looking gap
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      since_tick_reg <= '0;
    end else if (tick_reg) begin
      since_tick_reg <= '0;
    end else if (since_tick_reg != '1) begin
      since_tick_reg <= since_tick_reg + DIV_W'(1);
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      cfg_prev_reg <= '0;
      cfg_age_reg <= '0;
    end else begin
      cfg_prev_reg <= system_config_reg;
      if (!cfg_same) begin
        cfg_age_reg <= '0;
      end else if (cfg_age_reg != 4'hF) begin
        cfg_age_reg <= cfg_age_reg + 4'h1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      demod_meta_reg <= 1'b0;
      demod_sync_reg <= 1'b0;
      demod_last_reg <= 1'b0;
    end else begin
      demod_meta_reg <= demod_in;
      demod_sync_reg <= demod_meta_reg;
      demod_last_reg <= demod_sync_reg;
    end
  end

  assign pwd = system_config_reg.pulse_width_demod_bit;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      demod_rise_reg <= 1'b0;
      demod_fall_reg <= 1'b0;
    end else begin
      demod_rise_reg <= pwd && demod_sync_reg && !demod_last_reg;
      demod_fall_reg <= pwd && !demod_sync_reg && demod_last_reg;
    end
  end

  // in demodulation the first timer times the high phase, the second the low phase
  assign adv0 = pick_src(first_timer_mode_reg, tick_reg, full2) && (!pwd || demod_sync_reg);
  assign adv1 = pick_src(second_timer_mode_reg, tick_reg, full2) && (!pwd || !demod_sync_reg);
  assign adv2 = tick_reg;

  timer_chan #(.WIDTH(COUNT_W), .HAS_B(1'b1)) first_timer (
    .mclk(mclk), .rst_b(rst_b), .adv(adv0), .mode(first_timer_mode_reg),
    .limit_a(first_limits.a), .limit_b(first_limits.b),
    .count_reg(counts.first), .out_reg(first_timer_out), .phase_b_reg(ph0), .full_reg(full0), .irq_reg(irq0)
  );

  timer_chan #(.WIDTH(COUNT_W), .HAS_B(1'b1)) second_timer (
    .mclk(mclk), .rst_b(rst_b), .adv(adv1), .mode(second_timer_mode_reg),
    .limit_a(second_limits.a), .limit_b(second_limits.b),
    .count_reg(counts.second), .out_reg(second_timer_out), .phase_b_reg(), .full_reg(), .irq_reg(irq1)
  );

  timer_chan #(.WIDTH(COUNT_W), .HAS_B(1'b0)) third_timer (
    .mclk(mclk), .rst_b(rst_b), .adv(adv2), .mode(third_timer_mode_reg),
    .limit_a(third_limit), .limit_b(third_limit),
    .count_reg(counts.third), .out_reg(third_timer_out), .phase_b_reg(), .full_reg(full2), .irq_reg(irq2)
  );

  // counts are plain flop outputs, so reading them never perturbs counting
  assign timer_irq = {irq2, irq1, irq0};
  assign demod_rise_irq = demod_rise_reg;
  assign demod_fall_irq = demod_fall_reg;

  sequence rise_seen_s;
    pwd && demod_sync_reg && !demod_last_reg;
  endsequence

  sequence fall_seen_s;
    pwd && !demod_sync_reg && demod_last_reg;
  endsequence

  // looks back over one whole period, so a config change during the period before the tick cannot trip it
  tick_quarter_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (tick_reg && !system_config_reg.power_save && cfg_same && cfg_age_reg >= 4'h5)
      |-> since_tick_reg == DIV_W'(TICK_DIV - 1))
    else $error("tick not every fourth clock");

  tick_psave_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (tick_reg && system_config_reg.power_save && system_config_reg.psave_div == 8'h02
      && cfg_same && cfg_age_reg >= 4'h9)
      |-> since_tick_reg == DIV_W'(2 * TICK_DIV - 1))
    else $error("power save tick period wrong");

  count_wrap_a: assert property (@(posedge mclk) disable iff (!rst_b)
    full2 |-> counts.third == 16'h0000)
    else $error("third count not zero at full count");

  full_irq_a: assert property (@(posedge mclk) disable iff (!rst_b)
    full0 |-> timer_irq[0])
    else $error("full count without interrupt");

  dual_out_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (first_timer_mode_reg.enable && first_timer_mode_reg.dual_limit
      && $past(first_timer_mode_reg.enable) && $past(first_timer_mode_reg.dual_limit))
      |-> first_timer_out == !ph0)
    else $error("dual output does not follow limit phase");

  count_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
    !adv2 |=> $stable(counts.third))
    else $error("third count moved without a tick");

  count_freeze_a: assert property (@(posedge mclk) disable iff (!rst_b)
    !second_timer_mode_reg.enable |=> $stable(counts.second))
    else $error("disabled second timer count moved");

  prescale_src_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (first_timer_mode_reg.prescale_src && !pwd && first_timer_mode_reg.enable && !full2
      && counts.first != first_limits.a - 16'h0001 && counts.first != first_limits.b - 16'h0001)
      |=> $stable(counts.first))
    else $error("prescaled timer advanced without third timer full count");

  demod_rise_a: assert property (@(posedge mclk) disable iff (!rst_b)
    rise_seen_s |=> demod_rise_irq && !demod_fall_irq)
    else $error("rising edge interrupt missing");

  demod_fall_a: assert property (@(posedge mclk) disable iff (!rst_b)
    fall_seen_s |=> demod_fall_irq && !demod_rise_irq)
    else $error("falling edge interrupt missing");

  demod_off_a: assert property (@(posedge mclk) disable iff (!rst_b)
    !$past(pwd) |-> !demod_rise_irq && !demod_fall_irq)
    else $error("edge interrupt while demodulation off");
endmodule

// ===== demod_source.sv
`timescale 1ns/1ps
// far-side signal source: a steady high/low pulse train, idle low when stopped
module demod_source #(
  parameter int HI = 10,
  parameter int LO = 6
) (
  input wire logic mclk,
  input wire logic run,
  output logic level
);
  int n;
  initial begin
    n = 0;
    level = 1'b0;
  end
  always @(posedge mclk) begin
    if (!run) begin
      n <= 0;
      level <= 1'b0;
    end else begin
      n <= (n == HI + LO - 1) ? 0 : n + 1;
      level <= (n < HI);
    end
  end
endmodule

// ===== tb_triple_timer_pwm_pwd.sv
`timescale 1ns/1ps
module tb_triple_timer_pwm_pwd;
  import timer_pkg::*;
  logic mclk;
  logic rst_b;
  sysconf_type sysconf;
  mode_type m0, m1, m2;
  limit_type lim0, lim1;
  logic [COUNT_W-1:0] lim2;
  logic demod_in;
  logic src_run;
  counts_type counts;
  logic out0, out1, out2, rise_irq, fall_irq;
  logic [2:0] timer_irq;
  logic [7:0] ev;
  int failures;
  int num_checks;
  int hi, per;
  assign ev = {out0, out1, out2, fall_irq, rise_irq, timer_irq};

  triple_timer_pwm_pwd triple_timer_pwm_pwd_i (.mclk(mclk), .rst_b(rst_b), .system_config_reg(sysconf),
    .first_timer_mode_reg(m0), .second_timer_mode_reg(m1), .third_timer_mode_reg(m2), .first_limits(lim0),
    .second_limits(lim1), .third_limit(lim2), .demod_in(demod_in), .counts(counts), .first_timer_out(out0),
    .second_timer_out(out1), .third_timer_out(out2), .timer_irq(timer_irq), .demod_rise_irq(rise_irq),
    .demod_fall_irq(fall_irq));
  demod_source #(.HI(10), .LO(6)) demod_source_i (.mclk(mclk), .run(src_run), .level(demod_in));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task end_sim;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %0d seen %0d", name, exp, got);
    end
  endtask

  // outputs are registered on the rising edge, so they are sampled on the falling one
  task tick(inout int n);
    @(negedge mclk);
    n++;
    if (n > 500) begin
      failures++;
      $display("ERROR wait expected 500 seen %0d", n);
      end_sim();
    end
  endtask

  task wait_lvl(input int i, input logic v);
    int n;
    n = 0;
    while (ev[i] !== v) tick(n);
  endtask

  // high width and period, rise to rise; the first rise is skipped as it may follow a reconfiguration
  task meas(input int i, output int h, output int p);
    wait_lvl(i, 1'b1);
    wait_lvl(i, 1'b0);
    wait_lvl(i, 1'b1);
    p = 0;
    while (ev[i] === 1'b1) tick(p);
    h = p;
    while (ev[i] !== 1'b1) tick(p);
  endtask

  // parks every timer first so phases restart cleanly
  task setup(input logic [9:0] s, input logic [4:0] a, input logic [4:0] b, input logic [4:0] c);
    @(posedge mclk);
    m0 <= '0;
    m1 <= '0;
    m2 <= '0;
    repeat (2) @(posedge mclk);
    sysconf <= sysconf_type'(s);
    m0 <= mode_type'(a);
    m1 <= mode_type'(b);
    m2 <= mode_type'(c);
  endtask

  task t_single;
    lim2 <= 16'h0003;
    setup(10'h000, 5'h00, 5'h00, 5'h14);
    meas(2, hi, per);
    chk("third irq period", 12, per);
    meas(5, hi, per);
    chk("third out high", 12, hi);
    chk("third out period", 24, per);
    chk("third count bounded", 1, counts.third < 16'h0003);
  endtask

  task t_dual;
    @(posedge mclk);
    lim0 <= {16'h0002, 16'h0003};
    lim1 <= {16'h0005, 16'h0001};
    setup(10'h000, 5'h1C, 5'h14, 5'h00);
    meas(7, hi, per);
    chk("first out high", 8, hi);
    chk("first out period", 20, per);
    meas(0, hi, per);
    chk("first irq period", 20, per);
    meas(1, hi, per);
    chk("second irq period", 20, per);
    meas(6, hi, per);
    chk("second out high", 20, hi);
    chk("second out period", 40, per);
  endtask

  task t_psave;
    @(posedge mclk);
    lim2 <= 16'h0003;
    setup(10'h102, 5'h00, 5'h00, 5'h14);
    meas(2, hi, per);
    chk("slow third period", 24, per);
  endtask

  // limits never drop below a count left over from the last test, so no timer overruns
  task t_prescale;
    @(posedge mclk);
    lim2 <= 16'h0003;
    lim0 <= {16'h0003, 16'h0003};
    lim1 <= {16'h0005, 16'h0001};
    setup(10'h000, 5'h16, 5'h16, 5'h14);
    meas(1, hi, per);
    chk("prescaled period", 60, per);
    meas(0, hi, per);
    chk("first prescaled period", 36, per);
  endtask

  task t_demod;
    @(posedge mclk);
    lim0 <= {16'h0100, 16'h0100};
    lim1 <= {16'h0100, 16'h0100};
    setup(10'h200, 5'h14, 5'h14, 5'h00);
    src_run <= 1'b1;
    meas(3, hi, per);
    chk("rise irq period", 16, per);
    chk("rise irq width", 1, hi);
    meas(4, hi, per);
    chk("fall irq period", 16, per);
    chk("high phase counted", 1, counts.first !== 16'h0000);
    chk("low phase counted", 1, counts.second !== 16'h0000);
  endtask

  initial begin
    failures = 0;
    num_checks = 0;
    rst_b = 1'b0;
    src_run = 1'b0;
    sysconf = '0;
    m0 = '0;
    m1 = '0;
    m2 = '0;
    lim0 = '0;
    lim1 = '0;
    lim2 = '0;
    repeat (4) @(posedge mclk);
    rst_b <= 1'b1;
    t_single();
    t_dual();
    t_psave();
    t_prescale();
    t_demod();
    end_sim();
  end
endmodule
